// [rtl/pcgb_map.svh]
// Offsets, field positions, masks and reset values of the clock gate bank.
// Assumes byte addresses on an 8-bit register port with 32-bit data.
`ifndef PCGB_MAP_SVH
`define PCGB_MAP_SVH

`define PCGB_SYS_OFS       8'hb4
`define PCGB_APB_OFS       8'hb8
`define PCGB_SYS_STOP_OFS  8'he0
`define PCGB_SYS_START_OFS 8'he4
`define PCGB_APB_STOP_OFS  8'he8
`define PCGB_APB_START_OFS 8'hec
`define PCGB_SYS_STAT_OFS  8'hf0
`define PCGB_APB_STAT_OFS  8'hf4

`define PCGB_SYS_MASK 32'h007fff07
`define PCGB_APB_MASK 32'h00137fff
`define PCGB_SYS_RST  32'h007df700
`define PCGB_APB_RST  32'h00037fff
`define PCGB_SYS_W    23
`define PCGB_APB_W    21

`define PCGB_B_SD_B       22
`define PCGB_B_IMG_PROG   21
`define PCGB_B_TV_PROG    20
`define PCGB_B_VIDEO_PROG 19
`define PCGB_B_DRAM_B     18
`define PCGB_B_BOOT_ROM   17
`define PCGB_B_USB_FS     16
`define PCGB_B_SPI        15
`define PCGB_B_SD_A       14
`define PCGB_B_GRAPHICS   13
`define PCGB_B_STILL      12
`define PCGB_B_ETH_MAC    11
`define PCGB_B_CRYPT      10
`define PCGB_B_USB_HS     9
`define PCGB_B_DMA        8
`define PCGB_B_SYS_BUS_B  2
`define PCGB_B_AXI_BR_B   1
`define PCGB_B_AXI_BR_A   0

`define PCGB_B_PBRIDGE    20
`define PCGB_B_GPIO_B     17
`define PCGB_B_GPIO_A     16
`define PCGB_B_RTC        14
`define PCGB_B_TIMER_C    13
`define PCGB_B_TIMER_B    12
`define PCGB_B_TIMER_A    11
`define PCGB_B_WATCHDOG   10
`define PCGB_B_PWM        9
`define PCGB_B_ADC        8
`define PCGB_B_TWO_WIRE   7
`define PCGB_B_AUDIO      6
`define PCGB_B_SSP_B      5
`define PCGB_B_SSP_A      4
`define PCGB_B_IR_DET     3
`define PCGB_B_UART_C     2
`define PCGB_B_UART_B     1
`define PCGB_B_UART_A     0

`endif

// [rtl/pcgb_pkg.sv]
// Types shared by the clock gate bank modules.
// Assumes the register port carries an 8-bit byte address.
package pcgb_pkg;
    typedef logic [7:0]  pcgb_addr_t;
    typedef logic [31:0] pcgb_word_t;
    // Register selected by an address
    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_SYS,
        SEL_APB,
        SEL_SYS_STOP,
        SEL_SYS_START,
        SEL_APB_STOP,
        SEL_APB_START,
        SEL_SYS_STAT,
        SEL_APB_STAT
    } pcgb_sel_t;
endpackage : pcgb_pkg

// [rtl/pcgb_gate_if.sv]
// Carrier between the register file and one bank of clock gates.
// Assumes both ends sit on the same source clock.
`timescale 1ns/1ps
interface pcgb_gate_if #(parameter int unsigned WIDTH = 1);
    logic [WIDTH-1:0] stopReq;
    logic [WIDTH-1:0] gateOpen;
    logic [WIDTH-1:0] gatedClk;

    // Register side asks, gate side answers
    modport ctrl (
        output stopReq,
        input  gateOpen,
        input  gatedClk
    );
    modport bank (
        input  stopReq,
        output gateOpen,
        output gatedClk
    );
endinterface : pcgb_gate_if

// [rtl/pcgb_clock_gate.sv]
// A bank of glitch-free clock gates driven from one source clock.
// Assumes rstSyncN is already synchronous to clkSrc at release.
`timescale 1ns/1ps
module pcgb_clock_gate
    import pcgb_pkg::*;
#(
    parameter int unsigned     WIDTH         = 1,
    parameter logic [WIDTH-1:0] OPEN_AT_RESET = '0
) (
    // Clock and reset
    input wire logic clkSrc,
    input wire logic rstSyncN,
    // Gate requests and gated clocks
    pcgb_gate_if.bank gates
);
    logic [WIDTH-1:0] openFf;

    // Enable taken on the falling edge, so it only moves while the clock is low
    always_ff @(negedge clkSrc or negedge rstSyncN) begin
        if (!rstSyncN) begin
            openFf <= OPEN_AT_RESET;
        end else begin
            openFf <= ~gates.stopReq;
        end
    end

    // AND gate cannot clip a high phase: enable is stable during it
    assign gates.gatedClk = {WIDTH{clkSrc}} & openFf;
    assign gates.gateOpen = openFf;

endmodule : pcgb_clock_gate

// [rtl/pcgb_top.sv]
// Clock gate bank: two gating registers and the gated module clocks.
// Assumes a register master on clk_sys that never waits for an answer.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "pcgb_map.svh"
module pcgb_top
    import pcgb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Register port
    input  wire pcgb_addr_t  regAddr,
    input  wire pcgb_word_t  regWrData,
    input  wire logic        regWrStrobe,
    input  wire logic        regRdStrobe,
    output pcgb_word_t       regRdData,
    // System-bus module clocks
    output logic             sdCardCtrlBGate,
    output logic             imageProcessorProgGate,
    output logic             tvEncoderProgGate,
    output logic             videoEncoderProgGate,
    output logic             dramChannelBGate,
    output logic             bootRomGate,
    output logic             usbFullSpeedGate,
    output logic             spiCtrlGate,
    output logic             sdCardCtrlAGate,
    output logic             graphicsEngineGate,
    output logic             stillVideoCodecGate,
    output logic             ethernetMacGate,
    output logic             encryptionGate,
    output logic             usbHighSpeedGate,
    output logic             dmaGate,
    output logic             sysBusBGate,
    output logic             axiBridgeBGate,
    output logic             axiBridgeAGate,
    // Peripheral-bus module clocks
    output logic             peripheralBridgeGate,
    output logic             gpioBGate,
    output logic             gpioAGate,
    output logic             rtcGate,
    output logic             timerCGate,
    output logic             timerBGate,
    output logic             timerAGate,
    output logic             watchdogGate,
    output logic             pwmGate,
    output logic             adcWrapperGate,
    output logic             twoWireBusGate,
    output logic             audioCodecGate,
    output logic             syncSerialBGate,
    output logic             syncSerialAGate,
    output logic             irDetectorGate,
    output logic             uartCGate,
    output logic             uartBGate,
    output logic             uartAGate
);

    // Gate state held open at reset: writable bits whose reset value is 0
    localparam pcgb_word_t SYS_OPEN_RST = ~`PCGB_SYS_RST & `PCGB_SYS_MASK;
    localparam pcgb_word_t APB_OPEN_RST = ~`PCGB_APB_RST & `PCGB_APB_MASK;
    // Masks held as named words so that their low lanes can be sliced
    localparam pcgb_word_t SYS_MASK     = `PCGB_SYS_MASK;
    localparam pcgb_word_t APB_MASK     = `PCGB_APB_MASK;

    // Address decode, shared by the write and read paths
    function automatic pcgb_sel_t decodeAddr(input pcgb_addr_t addr);
        pcgb_sel_t sel;
        sel = SEL_NONE;
        case (addr)
            `PCGB_SYS_OFS:       sel = SEL_SYS;
            `PCGB_APB_OFS:       sel = SEL_APB;
            `PCGB_SYS_STOP_OFS:  sel = SEL_SYS_STOP;
            `PCGB_SYS_START_OFS: sel = SEL_SYS_START;
            `PCGB_APB_STOP_OFS:  sel = SEL_APB_STOP;
            `PCGB_APB_START_OFS: sel = SEL_APB_START;
            `PCGB_SYS_STAT_OFS:  sel = SEL_SYS_STAT;
            `PCGB_APB_STAT_OFS:  sel = SEL_APB_STAT;
            default:             sel = SEL_NONE;
        endcase
        return sel;
    endfunction : decodeAddr

    // Next gate word: full write, set-to-stop or clear-to-start
    function automatic pcgb_word_t nextGate(
        input pcgb_word_t cur,
        input pcgb_word_t data,
        input pcgb_word_t mask,
        input logic       full,
        input logic       stop,
        input logic       start
    );
        pcgb_word_t val;
        val = cur;
        if (full) begin
            val = data & mask;
        end else if (stop) begin
            val = (cur | data) & mask;
        end else if (start) begin
            val = cur & ~data & mask;
        end
        return val;
    endfunction : nextGate

    logic       rstMetaFf;
    logic       rstSyncFf;
    pcgb_sel_t  wrSel;
    pcgb_sel_t  rdSel;
    pcgb_word_t sysGateFf;
    pcgb_word_t apbGateFf;
    pcgb_word_t nxt_sysGate;
    pcgb_word_t nxt_apbGate;
    pcgb_word_t nxt_rdData;
    pcgb_word_t rdDataFf;
    pcgb_word_t sysRunning;
    pcgb_word_t apbRunning;

    pcgb_gate_if #(.WIDTH(`PCGB_SYS_W)) sysGates ();
    pcgb_gate_if #(.WIDTH(`PCGB_APB_W)) apbGates ();

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstMetaFf <= 1'b0;
            rstSyncFf <= 1'b0;
        end else begin
            rstMetaFf <= 1'b1;
            rstSyncFf <= rstMetaFf;
        end
    end

    // Decode only under a strobe so idle addresses do nothing
    assign wrSel = regWrStrobe ? decodeAddr(regAddr) : SEL_NONE;
    assign rdSel = regRdStrobe ? decodeAddr(regAddr) : SEL_NONE;

    // Reserved bits are masked off on every kind of write
    assign nxt_sysGate = nextGate(sysGateFf, regWrData, `PCGB_SYS_MASK,
                                  wrSel == SEL_SYS, wrSel == SEL_SYS_STOP,
                                  wrSel == SEL_SYS_START);
    assign nxt_apbGate = nextGate(apbGateFf, regWrData, `PCGB_APB_MASK,
                                  wrSel == SEL_APB, wrSel == SEL_APB_STOP,
                                  wrSel == SEL_APB_START);

    // System-bus gating word; reset stops most clocks, keeps ROM, MAC and the bus fabric
    always_ff @(posedge clk_sys or negedge rstSyncFf) begin
        if (!rstSyncFf) begin
            sysGateFf <= `PCGB_SYS_RST;
        end else begin
            sysGateFf <= nxt_sysGate;
        end
    end

    // Peripheral-bus gating word; only the bridge runs from reset
    always_ff @(posedge clk_sys or negedge rstSyncFf) begin
        if (!rstSyncFf) begin
            apbGateFf <= `PCGB_APB_RST;
        end else begin
            apbGateFf <= nxt_apbGate;
        end
    end

    // Running clocks as the gates really stand, reserved lanes forced out
    assign sysRunning = {{(32 - `PCGB_SYS_W){1'b0}}, sysGates.gateOpen}
                        & `PCGB_SYS_MASK;
    assign apbRunning = {{(32 - `PCGB_APB_W){1'b0}}, apbGates.gateOpen}
                        & `PCGB_APB_MASK;

    // Read mux; alias registers are write-only and read zero
    always_comb begin
        nxt_rdData = '0;
        case (rdSel)
            SEL_SYS:      nxt_rdData = sysGateFf;
            SEL_APB:      nxt_rdData = apbGateFf;
            SEL_SYS_STAT: nxt_rdData = sysRunning;
            SEL_APB_STAT: nxt_rdData = apbRunning;
            default:      nxt_rdData = '0;
        endcase
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rstSyncFf) begin
        if (!rstSyncFf) begin
            rdDataFf <= '0;
        end else begin
            rdDataFf <= nxt_rdData;
        end
    end

    assign regRdData = rdDataFf;

    // Reserved lanes are asked to stop so no stray clock toggles inside
    assign sysGates.stopReq = sysGateFf[`PCGB_SYS_W-1:0]
                              | ~SYS_MASK[`PCGB_SYS_W-1:0];
    assign apbGates.stopReq = apbGateFf[`PCGB_APB_W-1:0]
                              | ~APB_MASK[`PCGB_APB_W-1:0];

    // System-bus gate bank; starts in its reset state, not in a glitch
    pcgb_clock_gate #(
        .WIDTH         (`PCGB_SYS_W),
        .OPEN_AT_RESET (SYS_OPEN_RST[`PCGB_SYS_W-1:0])
    ) u_sysBank (
        .clkSrc   (clk_sys),
        .rstSyncN (rstSyncFf),
        .gates    (sysGates.bank)
    );

    // Peripheral-bus gate bank
    pcgb_clock_gate #(
        .WIDTH         (`PCGB_APB_W),
        .OPEN_AT_RESET (APB_OPEN_RST[`PCGB_APB_W-1:0])
    ) u_apbBank (
        .clkSrc   (clk_sys),
        .rstSyncN (rstSyncFf),
        .gates    (apbGates.bank)
    );

    // Media engines on the system bus
    assign sdCardCtrlBGate        = sysGates.gatedClk[`PCGB_B_SD_B];
    assign imageProcessorProgGate = sysGates.gatedClk[`PCGB_B_IMG_PROG];
    assign tvEncoderProgGate      = sysGates.gatedClk[`PCGB_B_TV_PROG];
    assign videoEncoderProgGate   = sysGates.gatedClk[`PCGB_B_VIDEO_PROG];
    assign dramChannelBGate       = sysGates.gatedClk[`PCGB_B_DRAM_B];

    // Boot path and network stay alive so the system can come up
    assign bootRomGate            = sysGates.gatedClk[`PCGB_B_BOOT_ROM];
    assign ethernetMacGate        = sysGates.gatedClk[`PCGB_B_ETH_MAC];

    // Host-facing controllers
    assign usbFullSpeedGate       = sysGates.gatedClk[`PCGB_B_USB_FS];
    assign usbHighSpeedGate       = sysGates.gatedClk[`PCGB_B_USB_HS];
    assign spiCtrlGate            = sysGates.gatedClk[`PCGB_B_SPI];
    assign sdCardCtrlAGate        = sysGates.gatedClk[`PCGB_B_SD_A];
    assign graphicsEngineGate     = sysGates.gatedClk[`PCGB_B_GRAPHICS];
    assign stillVideoCodecGate    = sysGates.gatedClk[`PCGB_B_STILL];
    assign encryptionGate         = sysGates.gatedClk[`PCGB_B_CRYPT];
    assign dmaGate                = sysGates.gatedClk[`PCGB_B_DMA];

    // Bus fabric; stopping these from software can hang the bus
    assign sysBusBGate            = sysGates.gatedClk[`PCGB_B_SYS_BUS_B];
    assign axiBridgeBGate         = sysGates.gatedClk[`PCGB_B_AXI_BR_B];
    assign axiBridgeAGate         = sysGates.gatedClk[`PCGB_B_AXI_BR_A];

    // Peripheral bridge runs from reset so slow peripherals stay reachable
    assign peripheralBridgeGate   = apbGates.gatedClk[`PCGB_B_PBRIDGE];

    // Pins, time keeping and supervision
    assign gpioBGate              = apbGates.gatedClk[`PCGB_B_GPIO_B];
    assign gpioAGate              = apbGates.gatedClk[`PCGB_B_GPIO_A];
    assign rtcGate                = apbGates.gatedClk[`PCGB_B_RTC];
    assign timerCGate             = apbGates.gatedClk[`PCGB_B_TIMER_C];
    assign timerBGate             = apbGates.gatedClk[`PCGB_B_TIMER_B];
    assign timerAGate             = apbGates.gatedClk[`PCGB_B_TIMER_A];
    assign watchdogGate           = apbGates.gatedClk[`PCGB_B_WATCHDOG];
    assign pwmGate                = apbGates.gatedClk[`PCGB_B_PWM];

    // Converters and serial ports
    assign adcWrapperGate         = apbGates.gatedClk[`PCGB_B_ADC];
    assign twoWireBusGate         = apbGates.gatedClk[`PCGB_B_TWO_WIRE];
    assign audioCodecGate         = apbGates.gatedClk[`PCGB_B_AUDIO];
    assign syncSerialBGate        = apbGates.gatedClk[`PCGB_B_SSP_B];
    assign syncSerialAGate        = apbGates.gatedClk[`PCGB_B_SSP_A];
    assign irDetectorGate         = apbGates.gatedClk[`PCGB_B_IR_DET];
    assign uartCGate              = apbGates.gatedClk[`PCGB_B_UART_C];
    assign uartBGate              = apbGates.gatedClk[`PCGB_B_UART_B];
    assign uartAGate              = apbGates.gatedClk[`PCGB_B_UART_A];

endmodule : pcgb_top

// [test/pcgb_assertions.sv]
// Checker for the clock gate bank: register port timing and gated clock behaviour.
// Assumes it is bound to pcgb_top and no strobe comes before the internal reset lifts.
`timescale 1ns/1ps
`include "pcgb_map.svh"
module pcgb_assertions
    import pcgb_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       reset_n,
    // Register port
    input wire pcgb_addr_t regAddr,
    input wire pcgb_word_t regWrData,
    input wire logic       regWrStrobe,
    input wire logic       regRdStrobe,
    input wire pcgb_word_t regRdData,
    // Watched gated clocks
    input wire logic       bootRomGate,
    input wire logic       ethernetMacGate,
    input wire logic       dmaGate,
    input wire logic       axiBridgeAGate,
    input wire logic       peripheralBridgeGate,
    input wire logic       uartAGate
);
    // Request steps shared by the properties
    sequence sys_wr;
        regWrStrobe && regAddr == `PCGB_SYS_OFS;
    endsequence
    sequence apb_wr;
        regWrStrobe && regAddr == `PCGB_APB_OFS;
    endsequence
    sequence sys_rd;
        regRdStrobe && regAddr == `PCGB_SYS_OFS;
    endsequence
    sequence apb_rd;
        regRdStrobe && regAddr == `PCGB_APB_OFS;
    endsequence

    // Any watched gate high; sampled before a rising edge it must be low
    logic anyGate;
    assign anyGate = bootRomGate | ethernetMacGate | dmaGate | axiBridgeAGate
                   | peripheralBridgeGate | uartAGate;

    chk_read_idle_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !$past(regRdStrobe) |-> regRdData == '0) else $error("read data not zero when idle");
    chk_sys_read_back: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sys_wr ##1 sys_rd |=> regRdData == ($past(regWrData, 2) & 32'h007fff07))
        else $error("system register read back wrong");
    chk_apb_read_back: assert property (@(posedge clk_sys) disable iff (!reset_n)
        apb_wr ##1 apb_rd |=> regRdData == ($past(regWrData, 2) & 32'h00137fff))
        else $error("peripheral register read back wrong");
    chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        regRdStrobe && !(regAddr inside {8'hb4, 8'hb8, 8'hf0, 8'hf4}) |=> regRdData == '0)
        else $error("unmapped read not zero");
    chk_mac_follows: assert property (@(negedge clk_sys) disable iff (!reset_n)
        sys_wr |-> ##2 ethernetMacGate == !$past(regWrData[11], 2))
        else $error("ethernet gate does not follow its bit");
    chk_uart_follows: assert property (@(negedge clk_sys) disable iff (!reset_n)
        apb_wr |-> ##2 uartAGate == !$past(regWrData[0], 2))
        else $error("uart gate does not follow its bit");
    chk_bridge_follows: assert property (@(negedge clk_sys) disable iff (!reset_n)
        apb_wr |-> ##2 peripheralBridgeGate == !$past(regWrData[20], 2))
        else $error("bridge gate does not follow its bit");
    chk_low_phase: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !anyGate) else $error("gated clock high during low phase");
    chk_reset_gates: assert property (@(negedge clk_sys) disable iff (!reset_n)
        $rose(reset_n) |-> bootRomGate && ethernetMacGate && axiBridgeAGate
            && peripheralBridgeGate && !dmaGate && !uartAGate)
        else $error("gates not at reset state");
endmodule : pcgb_assertions

bind pcgb_top pcgb_assertions chk (
    .clk_sys, .reset_n, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
    .bootRomGate, .ethernetMacGate, .dmaGate, .axiBridgeAGate, .peripheralBridgeGate,
    .uartAGate
);

// [test/peripheral_clock_gate_bank_test.sv]
// Self-checking bench for the clock gate bank: register tasks and gate sampling.
// Assumes pcgb_top with its map header and package; the checker is bound separately.
`timescale 1ns/1ps
`include "pcgb_map.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errorCnt++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module peripheral_clock_gate_bank_test
    import pcgb_pkg::*;
;
    localparam pcgb_word_t SYS_M = 32'h007fff07;
    localparam pcgb_word_t APB_M = 32'h00137fff;
    localparam pcgb_word_t SYS_R = 32'h007df700;
    localparam pcgb_word_t APB_R = 32'h00037fff;

    logic       clk_sys, reset_n, regWrStrobe, regRdStrobe;
    pcgb_addr_t regAddr;
    pcgb_word_t regWrData, regRdData, sysRun, apbRun;
    logic sdCardCtrlBGate, imageProcessorProgGate, tvEncoderProgGate, videoEncoderProgGate;
    logic dramChannelBGate, bootRomGate, usbFullSpeedGate, spiCtrlGate, sdCardCtrlAGate;
    logic graphicsEngineGate, stillVideoCodecGate, ethernetMacGate, encryptionGate;
    logic usbHighSpeedGate, dmaGate, sysBusBGate, axiBridgeBGate, axiBridgeAGate;
    logic peripheralBridgeGate, gpioBGate, gpioAGate, rtcGate, timerCGate, timerBGate;
    logic timerAGate, watchdogGate, pwmGate, adcWrapperGate, twoWireBusGate, audioCodecGate;
    logic syncSerialBGate, syncSerialAGate, irDetectorGate, uartCGate, uartBGate, uartAGate;
    int         errorCnt = 0;
    int         checks = 0;

    pcgb_top DUT (.*);

    // Gate outputs gathered at their register bit positions
    assign sysRun = {9'h0, sdCardCtrlBGate, imageProcessorProgGate, tvEncoderProgGate,
        videoEncoderProgGate, dramChannelBGate, bootRomGate, usbFullSpeedGate, spiCtrlGate,
        sdCardCtrlAGate, graphicsEngineGate, stillVideoCodecGate, ethernetMacGate,
        encryptionGate, usbHighSpeedGate, dmaGate, 5'h0, sysBusBGate, axiBridgeBGate,
        axiBridgeAGate};
    assign apbRun = {11'h0, peripheralBridgeGate, 2'h0, gpioBGate, gpioAGate, 1'h0, rtcGate,
        timerCGate, timerBGate, timerAGate, watchdogGate, pwmGate, adcWrapperGate,
        twoWireBusGate, audioCodecGate, syncSerialBGate, syncSerialAGate, irDetectorGate,
        uartCGate, uartBGate, uartAGate};

    // Gated clocks may only move on a clock edge, never inside a phase
    always @(sysRun or apbRun) begin
        `CHK("gate edge timing", 1'b1, int'($realtime * 2.0) % 25 == 0)
    end

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // One bus cycle; a request stands exactly one cycle, so no wait is needed
    task bus(input logic w, input logic r, input pcgb_addr_t a, input pcgb_word_t d);
        @(posedge clk_sys);
        regWrStrobe <= w;
        regRdStrobe <= r;
        regAddr     <= a;
        regWrData   <= d;
    endtask : bus

    task wr(input pcgb_addr_t a, input pcgb_word_t d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample there
    task rd(input pcgb_addr_t a, input pcgb_word_t exp, input string nm);
        bus(1'b0, 1'b1, a, '0);
        bus(1'b0, 1'b0, a, '0);
        #1;
        `CHK(nm, exp, regRdData)
    endtask : rd

    // High phase shows running clocks, low phase must be quiet
    task gates(input pcgb_word_t s, input pcgb_word_t p);
        repeat (2) @(posedge clk_sys);
        #2;
        `CHK("sys gates high", ~s & SYS_M, sysRun)
        `CHK("apb gates high", ~p & APB_M, apbRun)
        @(negedge clk_sys);
        #2;
        `CHK("sys gates low", 32'h0, sysRun)
        `CHK("apb gates low", 32'h0, apbRun)
    endtask : gates

    task do_reset;
        reset_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask : do_reset

    task give_verdict;
        $display("checks %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // Watchdog, well beyond the roughly 340 cycles the tests take
    initial begin
        repeat (6000) @(posedge clk_sys);
        errorCnt++;
        give_verdict();
    end

    initial begin
        {reset_n, regWrStrobe, regRdStrobe, regAddr, regWrData} = '0;
        do_reset();
        rd(`PCGB_SYS_OFS, SYS_R, "sys reset");
        rd(`PCGB_APB_OFS, APB_R, "apb reset");
        gates(SYS_R, APB_R);
        $display("test reset values done");
        wr(`PCGB_SYS_OFS, 32'hffffffff);
        rd(`PCGB_SYS_OFS, SYS_M, "sys all ones");
        wr(`PCGB_APB_OFS, 32'hffffffff);
        rd(`PCGB_APB_OFS, APB_M, "apb all ones");
        gates(SYS_M, APB_M);
        wr(`PCGB_SYS_OFS, 32'h0);
        rd(`PCGB_SYS_OFS, 32'h0, "sys zeros");
        wr(`PCGB_APB_OFS, 32'h0);
        rd(`PCGB_APB_OFS, 32'h0, "apb zeros");
        gates(32'h0, 32'h0);
        $display("test full patterns done");
        for (int i = 0; i < 32; i++) begin
            wr(`PCGB_SYS_OFS, 32'h1 << i);
            wr(`PCGB_APB_OFS, 32'h1 << i);
            rd(`PCGB_SYS_OFS, (32'h1 << i) & SYS_M, "sys walk");
            rd(`PCGB_APB_OFS, (32'h1 << i) & APB_M, "apb walk");
            gates((32'h1 << i) & SYS_M, (32'h1 << i) & APB_M);
        end
        $display("test walking bit done");
        wr(`PCGB_SYS_STOP_OFS, 32'hffffffff);
        rd(`PCGB_SYS_OFS, SYS_M, "sys stop set");
        wr(`PCGB_SYS_START_OFS, 32'h00020801);
        rd(`PCGB_SYS_OFS, SYS_M & ~32'h00020801, "sys start clear");
        rd(`PCGB_SYS_STAT_OFS, 32'h00020801, "sys status");
        wr(`PCGB_APB_STOP_OFS, 32'h00000011);
        wr(`PCGB_APB_START_OFS, 32'h00000001);
        rd(`PCGB_APB_OFS, 32'h00000010, "apb stop start");
        rd(`PCGB_APB_STAT_OFS, APB_M & ~32'h00000010, "apb status");
        rd(`PCGB_SYS_STOP_OFS, 32'h0, "alias reads zero");
        wr(`PCGB_SYS_STAT_OFS, 32'hffffffff);
        rd(`PCGB_SYS_STAT_OFS, 32'h00020801, "status write ignored");
        gates(SYS_M & ~32'h00020801, 32'h00000010);
        $display("test alias and status done");
        wr(`PCGB_SYS_OFS, 32'h00000100);
        wr(8'hb0, 32'hffffffff);
        wr(8'hbc, 32'hffffffff);
        wr(8'h00, 32'hffffffff);
        rd(8'hb0, 32'h0, "unmapped b0");
        rd(8'hbc, 32'h0, "unmapped bc");
        rd(`PCGB_SYS_OFS, 32'h00000100, "sys kept");
        $display("test unmapped done");
        @(posedge clk_sys);
        do_reset();
        rd(`PCGB_SYS_OFS, SYS_R, "sys second reset");
        rd(`PCGB_APB_OFS, APB_R, "apb second reset");
        gates(SYS_R, APB_R);
        $display("test second reset done");
        give_verdict();
    end
endmodule : peripheral_clock_gate_bank_test
